// *** core/lfc_pkg.sv ***
// Purpose: constants for the linefeed state and dc feed control block
// Assumes: classic wishbone, 32-bit data, byte addresses = 4 x register index
// Notes: voltage codes step 1.5 V, current codes step 3 mA from 20 mA
package lfc_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] LFC_IDX_STATE = 8'h40;
   localparam logic [7:0] LFC_IDX_LOOP_CURRENT_LIMIT = 8'h47;
   localparam logic [7:0] LFC_IDX_VOC = 8'h48;
   localparam logic [7:0] LFC_IDX_VCM = 8'h49;
   localparam logic [7:0] LFC_IDX_CTRL = 8'h50;
   localparam logic [7:0] LFC_IDX_IRQ_STAT = 8'h51;
   localparam logic [7:0] LFC_IDX_IRQ_CLR = 8'h52;
   localparam logic [7:0] LFC_IDX_IRQ_EN = 8'h53;
   localparam logic [7:0] LFC_IDX_MEAS = 8'h54;
   localparam int LFC_ADDR_W = 10;

   // ****************************************************************
   // field widths and reset values
   // ****************************************************************
   localparam int LFC_STATE_W = 3;
   localparam int LFC_LOOP_CURRENT_LIMIT_W = 3;
   localparam int LFC_VOLT_W = 6;
   localparam int LFC_IRQ_W = 1;
   localparam int LFC_IRQ_PWR_BIT = 0;
   localparam int LFC_CTRL_AUTO_OPEN_ON_POWER_ALARM_BIT = 0;
   localparam logic [2:0] LFC_LOOP_CURRENT_LIMIT_RST = 3'h0;   // 20 mA
   localparam logic [5:0] LFC_VOC_RST = 6'h20;   // 32 x 1.5 V = 48 V
   localparam logic [5:0] LFC_VCM_RST = 6'h02;   // 2 x 1.5 V = 3 V
   localparam logic [2:0] LFC_LOOP_CURRENT_LIMIT_MAX = 3'h7;
   localparam int LFC_LOOP_CURRENT_LIMIT_BASE_MA = 20;
   localparam int LFC_LOOP_CURRENT_LIMIT_STEP_MA = 3;

   // ****************************************************************
   // linefeed states
   // ****************************************************************
   typedef enum logic [2:0] {
      LFC_OPEN = 3'h0,
      LFC_FWD_ACT = 3'h1,
      LFC_FWD_OHT = 3'h2,
      LFC_TIP_OPEN = 3'h3,
      LFC_RINGING = 3'h4,
      LFC_REV_ACT = 3'h5,
      LFC_REV_OHT = 3'h6,
      LFC_RING_OPEN = 3'h7
   } lfc_state_e;
endpackage : lfc_pkg

// *** core/lfc_drive_dec.sv ***
// Purpose: registered decode of a linefeed state into driver and path enables
// Assumes: state value arrives one cycle before the enables change
// Notes: outputs are flip-flops
`timescale 1ns/1ns
module lfc_drive_dec (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // state in
   input wire lfc_pkg::lfc_state_e state_i,
   // enables out
   output logic tip_drive_en_o,
   output logic ring_drive_en_o,
   output logic audio_pwr_en_o,
   output logic ringing_sel_o,
   output logic reverse_pol_o
);
   import lfc_pkg::*;

   typedef struct packed {
      logic tip;
      logic ring;
      logic audio;
      logic rng;
      logic rev;
   } lfc_dec_s;

   lfc_dec_s s_q;
   lfc_dec_s s_d;

   always_comb begin
      s_d = '0;
      case (state_i)
         LFC_OPEN: begin
            s_d = '0; // RQ2
         end
         LFC_FWD_ACT: begin
            s_d.tip = 1'b1; // RQ4
            s_d.ring = 1'b1;
         end
         LFC_REV_ACT: begin
            s_d.tip = 1'b1; // RQ4
            s_d.ring = 1'b1;
            s_d.rev = 1'b1; // RQ14
         end
         LFC_FWD_OHT: begin
            s_d.tip = 1'b1;
            s_d.ring = 1'b1;
            s_d.audio = 1'b1; // RQ5
         end
         LFC_REV_OHT: begin
            s_d.tip = 1'b1;
            s_d.ring = 1'b1;
            s_d.audio = 1'b1; // RQ5
            s_d.rev = 1'b1;
         end
         LFC_TIP_OPEN: begin
            s_d.ring = 1'b1; // RQ6
         end
         LFC_RING_OPEN: begin
            s_d.tip = 1'b1; // RQ7
         end
         LFC_RINGING: begin
            s_d.tip = 1'b1;
            s_d.ring = 1'b1;
            s_d.rng = 1'b1; // RQ8
         end
         default: begin
            s_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tip_drive_en_o = s_q.tip;
   assign ring_drive_en_o = s_q.ring;
   assign audio_pwr_en_o = s_q.audio;
   assign ringing_sel_o = s_q.rng;
   assign reverse_pol_o = s_q.rev;
endmodule : lfc_drive_dec

// *** core/lfc_top.sv ***
// Purpose: linefeed state register, dc feed settings and power alarm handling
// Assumes: classic wishbone slave, one 10 MHz clock, synchronous reset
// Notes: overview follows
// Overview of operation
// [RQ1] eight states, chosen by state register
// [RQ2] open state drops all drive enables
// [RQ3] power alarm may force open state
// [RQ4] active states: drive on, audio off
// [RQ5] on-hook transmission states power audio paths
// [RQ6] tip open: tip off, ring driven
// [RQ7] ring open: ring off, tip driven
// [RQ8] ringing state routes ringing generator out
// [RQ9] six-bit open voltage, default 48 V
// [RQ10] three-bit current limit, default 20 mA
// [RQ11] six-bit common-mode offset, default 3 V
// [RQ12] software sets feed before active state
// [RQ13] measurement runs in every state
// [RQ14] fixed three-bit state code decode
// [RQ15] alarm sets status, irq; open if enabled
// [RQ16] linear code scaling, current saturates above seven
// [RQ17] auto open shows in state register
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
module lfc_top #(
   parameter int LOOP_CURRENT_LIMIT_MA_W = 6
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [lfc_pkg::LFC_ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // power monitor and measurement
   input wire logic power_alarm_i,
   input wire logic meas_strobe_i,
   // linefeed control
   output logic tip_drive_en_o,
   output logic ring_drive_en_o,
   output logic audio_pwr_en_o,
   output logic ringing_sel_o,
   output logic reverse_pol_o,
   output logic meas_en_o,
   output logic [lfc_pkg::LFC_LOOP_CURRENT_LIMIT_W-1:0] loop_current_limit_o,
   output logic [LOOP_CURRENT_LIMIT_MA_W-1:0] loop_current_limit_ma_o,
   output logic [lfc_pkg::LFC_VOLT_W-1:0] open_circuit_voltage_o,
   output logic [lfc_pkg::LFC_VOLT_W-1:0] common_mode_offset_o,
   output logic [2:0] line_state_select_o,
   // interrupt
   output logic irq_o
);
   import lfc_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      lfc_state_e state;
      logic [LFC_LOOP_CURRENT_LIMIT_W-1:0] loop_current_limit;
      logic [LOOP_CURRENT_LIMIT_MA_W-1:0] loop_current_limit_ma;
      logic [LFC_VOLT_W-1:0] open_circuit_voltage_reg;
      logic [LFC_VOLT_W-1:0] common_mode_voltage_reg;
      logic auto_open_on_power_alarm;
      logic [LFC_IRQ_W-1:0] stat;
      logic [LFC_IRQ_W-1:0] en;
      logic alarm_prev;
      logic [15:0] meas_cnt;
      logic meas_en;
      logic irq;
      logic ack;
      logic [31:0] rdat;
   } lfc_top_s;

   lfc_top_s s_q;
   lfc_top_s s_d;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [7:0] reg_index(input logic [LFC_ADDR_W-1:0] a);
      reg_index = a[LFC_ADDR_W-1:2];
   endfunction : reg_index

   function automatic logic [LOOP_CURRENT_LIMIT_MA_W-1:0] loop_current_limit_to_ma(input logic [LFC_LOOP_CURRENT_LIMIT_W-1:0] c);
      logic [LFC_LOOP_CURRENT_LIMIT_W-1:0] cs;
      cs = (c > LFC_LOOP_CURRENT_LIMIT_MAX) ? LFC_LOOP_CURRENT_LIMIT_MAX : c;
      loop_current_limit_to_ma = LOOP_CURRENT_LIMIT_MA_W'(LFC_LOOP_CURRENT_LIMIT_BASE_MA + LFC_LOOP_CURRENT_LIMIT_STEP_MA * int'(cs)); // RQ16
   endfunction : loop_current_limit_to_ma

   logic req;
   logic wr;
   logic alarm_rise;
   logic [7:0] idx;

   always_comb begin
      req = cyc_i && stb_i && !s_q.ack;
      wr = req && we_i && sel_i[0];
      idx = reg_index(adr_i);
      alarm_rise = power_alarm_i && !s_q.alarm_prev;
      s_d = s_q;
      s_d.ack = req;
      s_d.meas_en = 1'b1; // RQ13
      s_d.alarm_prev = power_alarm_i;
      s_d.loop_current_limit_ma = loop_current_limit_to_ma(s_q.loop_current_limit); // RQ16
      if (meas_strobe_i) begin
         s_d.meas_cnt = s_q.meas_cnt + 16'h0001; // RQ13
      end
      // register writes
      if (wr) begin
         case (idx)
            LFC_IDX_STATE: s_d.state = lfc_state_e'(dat_i[LFC_STATE_W-1:0]); // RQ1 RQ14
            LFC_IDX_LOOP_CURRENT_LIMIT: s_d.loop_current_limit = dat_i[LFC_LOOP_CURRENT_LIMIT_W-1:0]; // RQ10
            LFC_IDX_VOC: s_d.open_circuit_voltage_reg = dat_i[LFC_VOLT_W-1:0]; // RQ9
            LFC_IDX_VCM: s_d.common_mode_voltage_reg = dat_i[LFC_VOLT_W-1:0]; // RQ11
            LFC_IDX_CTRL: s_d.auto_open_on_power_alarm = dat_i[LFC_CTRL_AUTO_OPEN_ON_POWER_ALARM_BIT];
            LFC_IDX_IRQ_CLR: s_d.stat = s_q.stat & ~dat_i[LFC_IRQ_W-1:0];
            LFC_IDX_IRQ_EN: s_d.en = dat_i[LFC_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // alarm set wins over clear; auto open wins over a state write
      if (alarm_rise) begin
         s_d.stat[LFC_IRQ_PWR_BIT] = 1'b1; // RQ15
         if (s_q.auto_open_on_power_alarm) begin
            s_d.state = LFC_OPEN; // RQ3 RQ15 RQ17
         end
      end
      s_d.irq = |(s_d.stat & s_d.en); // RQ15
      // read data
      s_d.rdat = 32'h0;
      if (req && !we_i) begin
         case (idx)
            LFC_IDX_STATE: s_d.rdat = {29'h0, s_q.state}; // RQ17
            LFC_IDX_LOOP_CURRENT_LIMIT: s_d.rdat = {29'h0, s_q.loop_current_limit};
            LFC_IDX_VOC: s_d.rdat = {26'h0, s_q.open_circuit_voltage_reg};
            LFC_IDX_VCM: s_d.rdat = {26'h0, s_q.common_mode_voltage_reg};
            LFC_IDX_CTRL: s_d.rdat = {31'h0, s_q.auto_open_on_power_alarm};
            LFC_IDX_IRQ_STAT: s_d.rdat = {31'h0, s_q.stat};
            LFC_IDX_IRQ_EN: s_d.rdat = {31'h0, s_q.en};
            LFC_IDX_MEAS: s_d.rdat = {16'h0, s_q.meas_cnt};
            default: s_d.rdat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.state <= LFC_OPEN;
         s_q.loop_current_limit <= LFC_LOOP_CURRENT_LIMIT_RST; // RQ10
         s_q.loop_current_limit_ma <= LOOP_CURRENT_LIMIT_MA_W'(LFC_LOOP_CURRENT_LIMIT_BASE_MA);
         s_q.open_circuit_voltage_reg <= LFC_VOC_RST; // RQ9
         s_q.common_mode_voltage_reg <= LFC_VCM_RST; // RQ11
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // driver decode
   // ****************************************************************
   lfc_drive_dec u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .state_i(s_q.state),
      .tip_drive_en_o(tip_drive_en_o),
      .ring_drive_en_o(ring_drive_en_o),
      .audio_pwr_en_o(audio_pwr_en_o),
      .ringing_sel_o(ringing_sel_o),
      .reverse_pol_o(reverse_pol_o)
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign meas_en_o = s_q.meas_en;
   assign dat_o = s_q.rdat;
   assign ack_o = s_q.ack;
   assign irq_o = s_q.irq;
   assign loop_current_limit_o = s_q.loop_current_limit;
   assign loop_current_limit_ma_o = s_q.loop_current_limit_ma;
   assign open_circuit_voltage_o = s_q.open_circuit_voltage_reg;
   assign common_mode_offset_o = s_q.common_mode_voltage_reg;
   assign line_state_select_o = s_q.state;
endmodule : lfc_top

// *** sim/lfc_checker.sv ***
// Purpose: port assertions for the linefeed control block
// Assumes: one clock, synchronous active-high reset
// Notes: drive enables trail the state register by one edge
`timescale 1ns/1ns
module lfc_checker #(
   parameter int LOOP_CURRENT_LIMIT_MA_W = 6
) (
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ack_o,
   input wire logic power_alarm_i,
   input wire logic tip_drive_en_o,
   input wire logic ring_drive_en_o,
   input wire logic audio_pwr_en_o,
   input wire logic reverse_pol_o,
   input wire logic meas_en_o,
   input wire logic [2:0] loop_current_limit_o,
   input wire logic [LOOP_CURRENT_LIMIT_MA_W-1:0] loop_current_limit_ma_o,
   input wire logic [2:0] line_state_select_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic [2:0] st = line_state_select_o;
   wire logic dr = tip_drive_en_o && ring_drive_en_o;
   property p_open; st == 3'h0 |=> !tip_drive_en_o && !ring_drive_en_o; endproperty
   a_open: assert property (p_open) else $error("drive on in open");
   property p_act; st inside {3'h1, 3'h5} |=> dr && !audio_pwr_en_o && reverse_pol_o == $past(st[2]);
   endproperty
   a_act: assert property (p_act) else $error("active decode wrong");
   property p_oht; st inside {3'h2, 3'h6} |=> dr && audio_pwr_en_o; endproperty
   a_oht: assert property (p_oht) else $error("on-hook audio off");
   property p_tipo; st == 3'h3 |=> !tip_drive_en_o && ring_drive_en_o; endproperty
   a_tipo: assert property (p_tipo) else $error("tip open decode wrong");
   property p_ringo; st == 3'h7 |=> tip_drive_en_o && !ring_drive_en_o; endproperty
   a_ringo: assert property (p_ringo) else $error("ring open decode wrong");
   property p_src;
      $changed(st) |-> ack_o || ($past(power_alarm_i) && !$past(power_alarm_i, 2));
   endproperty
   a_src: assert property (p_src) else $error("state changed unasked");
   property p_irqr; $rose(irq_o) |-> ack_o || ($past(power_alarm_i) && !$past(power_alarm_i, 2));
   endproperty
   a_irqr: assert property (p_irqr) else $error("irq rose unasked");
   property p_irqf; $fell(irq_o) |-> ack_o; endproperty
   a_irqf: assert property (p_irqf) else $error("irq fell without write");
   property p_ma; !rst_i |=> loop_current_limit_ma_o == 20 + 3 * $past(loop_current_limit_o);
   endproperty
   a_ma: assert property (p_ma) else $error("current scaling wrong");
   property p_meas; !$past(rst_i) |-> meas_en_o; endproperty
   a_meas: assert property (p_meas) else $error("measurement stopped");
   c_ring: cover property (st == 3'h4);
   c_irq: cover property ($rose(irq_o));
   c_clr: cover property ($fell(irq_o));
endmodule : lfc_checker

// *** sim/lfc_line_model.sv ***
// Purpose: behavioural tip and ring driver stage
// Assumes: enables are levels
// Notes: 0 floating, 1 dc fed, 2 ringing
`timescale 1ns/1ns
module lfc_line_model (
   // enables in
   input wire logic tip_drive_en_i,
   input wire logic ring_drive_en_i,
   input wire logic ringing_sel_i,
   // line condition out
   output logic [1:0] tip_line_o,
   output logic [1:0] ring_line_o
);
   assign tip_line_o = !tip_drive_en_i ? 2'h0 : (ringing_sel_i ? 2'h2 : 2'h1);
   assign ring_line_o = !ring_drive_en_i ? 2'h0 : (ringing_sel_i ? 2'h2 : 2'h1);
endmodule : lfc_line_model

// *** sim/tb.sv ***
// Purpose: self-checking bench for lfc_top
// Assumes: classic wishbone, 100 ns clock
// Notes: line condition seen through the driver model
`timescale 1ns/1ns
module tb;
   import lfc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, power_alarm_i = 1'b0, meas_strobe_i = 1'b0;
   logic [LFC_ADDR_W-1:0] adr_i = '0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, tip_drive_en_o, ring_drive_en_o, audio_pwr_en_o, ringing_sel_o;
   logic reverse_pol_o, meas_en_o, irq_o;
   logic [2:0] loop_current_limit_o, line_state_select_o;
   logic [5:0] loop_current_limit_ma_o, open_circuit_voltage_o, common_mode_offset_o;
   logic [1:0] tip_line, ring_line;
   int errors = 0, checks = 0;
   always #50 clk_i = ~clk_i;
   lfc_top #(.LOOP_CURRENT_LIMIT_MA_W(6)) lfc_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .power_alarm_i(power_alarm_i), .meas_strobe_i(meas_strobe_i),
      .tip_drive_en_o(tip_drive_en_o), .ring_drive_en_o(ring_drive_en_o),
      .audio_pwr_en_o(audio_pwr_en_o), .ringing_sel_o(ringing_sel_o),
      .reverse_pol_o(reverse_pol_o), .meas_en_o(meas_en_o),
      .loop_current_limit_o(loop_current_limit_o),
      .loop_current_limit_ma_o(loop_current_limit_ma_o),
      .open_circuit_voltage_o(open_circuit_voltage_o),
      .common_mode_offset_o(common_mode_offset_o),
      .line_state_select_o(line_state_select_o), .irq_o(irq_o));
   lfc_line_model lfc_line_model_i (.tip_drive_en_i(tip_drive_en_o),
      .ring_drive_en_i(ring_drive_en_o), .ringing_sel_i(ringing_sel_o),
      .tip_line_o(tip_line), .ring_line_o(ring_line));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
      adr_i <= {idx, 2'b00};
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_i);
      end
      chk("ack", 32'h1, 32'(ack_o));
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask : wb
   task automatic rc(input logic [7:0] idx, input logic [31:0] e, input string n);
      wb(1'b0, idx, 32'h0);
      chk(n, e, rd);
   endtask : rc
   task automatic t_defaults;
      rc(LFC_IDX_STATE, 32'h0, "state");
      rc(LFC_IDX_LOOP_CURRENT_LIMIT, 32'h0, "loop_current_limit");
      rc(LFC_IDX_VOC, 32'h20, "voc");
      rc(LFC_IDX_VCM, 32'h2, "vcm");
      rc(8'h41, 32'h0, "unmapped");
      $display("test defaults done");
   endtask : t_defaults
   task automatic t_feed;
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, LFC_IDX_LOOP_CURRENT_LIMIT, 32'(c));
         repeat (2) @(posedge clk_i);
         chk("ma", 32'(20 + 3 * c), 32'(loop_current_limit_ma_o));
         chk("loop_current_limit_o", 32'(c), 32'(loop_current_limit_o));
      end
      wb(1'b1, LFC_IDX_VOC, 32'h3f);
      wb(1'b1, LFC_IDX_VCM, 32'h5);
      rc(LFC_IDX_VOC, 32'h3f, "voc");
      rc(LFC_IDX_VCM, 32'h5, "vcm");
      chk("voc_o", 32'h3f, 32'(open_circuit_voltage_o));
      chk("vcm_o", 32'h5, 32'(common_mode_offset_o));
      $display("test feed done");
   endtask : t_feed
   task automatic t_states;
      logic [1:0] te, re;
      for (int c = 0; c < 8; c++) begin
         te = (c == 0 || c == 3) ? 2'h0 : (c == 4 ? 2'h2 : 2'h1);
         re = (c == 0 || c == 7) ? 2'h0 : (c == 4 ? 2'h2 : 2'h1);
         wb(1'b1, LFC_IDX_STATE, 32'(c));
         @(posedge clk_i);
         meas_strobe_i <= 1'b1;
         @(posedge clk_i);
         meas_strobe_i <= 1'b0;
         @(posedge clk_i);
         chk("tip", 32'(te), 32'(tip_line));
         chk("ring", 32'(re), 32'(ring_line));
         chk("rev", 32'(c == 5 || c == 6), 32'(reverse_pol_o));
         if (c inside {0, 1, 2, 5, 6})
            chk("audio", 32'(c == 2 || c == 6), 32'(audio_pwr_en_o));
         rc(LFC_IDX_STATE, 32'(c), "state");
      end
      rc(LFC_IDX_MEAS, 32'h8, "meas");
      $display("test states done");
   endtask : t_states
   task automatic t_alarm;
      wb(1'b1, LFC_IDX_CTRL, 32'h1);
      wb(1'b1, LFC_IDX_IRQ_EN, 32'h1);
      wb(1'b1, LFC_IDX_STATE, 32'h1);
      power_alarm_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("irq", 32'h1, 32'(irq_o));
      chk("tip", 32'h0, 32'(tip_line));
      rc(LFC_IDX_STATE, 32'h0, "state");
      chk("lss", 32'h0, 32'(line_state_select_o));
      rc(LFC_IDX_IRQ_STAT, 32'h1, "stat");
      wb(1'b1, LFC_IDX_IRQ_CLR, 32'h1);
      power_alarm_i <= 1'b0;
      @(posedge clk_i);
      chk("irq", 32'h0, 32'(irq_o));
      wb(1'b1, LFC_IDX_CTRL, 32'h0);
      wb(1'b1, LFC_IDX_IRQ_EN, 32'h0);
      wb(1'b1, LFC_IDX_STATE, 32'h5);
      power_alarm_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("irq", 32'h0, 32'(irq_o));
      rc(LFC_IDX_STATE, 32'h5, "state");
      rc(LFC_IDX_IRQ_STAT, 32'h1, "stat");
      wb(1'b1, LFC_IDX_IRQ_EN, 32'h1);
      @(posedge clk_i);
      chk("irq", 32'h1, 32'(irq_o));
      wb(1'b1, LFC_IDX_IRQ_CLR, 32'h1);
      @(posedge clk_i);
      chk("irq", 32'h0, 32'(irq_o));
      $display("test alarm done");
   endtask : t_alarm
   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_defaults();
      t_feed();
      t_states();
      t_alarm();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      conclude();
   end
endmodule : tb
bind lfc_top lfc_checker #(.LOOP_CURRENT_LIMIT_MA_W(LOOP_CURRENT_LIMIT_MA_W)) lfc_checker_i (.clk_i(clk_i), .rst_i(rst_i),
   .ack_o(ack_o), .power_alarm_i(power_alarm_i), .tip_drive_en_o(tip_drive_en_o),
   .ring_drive_en_o(ring_drive_en_o), .audio_pwr_en_o(audio_pwr_en_o),
   .reverse_pol_o(reverse_pol_o), .meas_en_o(meas_en_o),
   .loop_current_limit_o(loop_current_limit_o), .loop_current_limit_ma_o(loop_current_limit_ma_o),
   .line_state_select_o(line_state_select_o), .irq_o(irq_o));
